/* rtl/mcu_instruction_decode_core.sv */
// Instruction fetch, decode and execute core with its register file
`timescale 1ns/1ps
module mcu_instruction_decode_core #(
  parameter int BANKS = 4
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Option strap, four clocks per cycle when high
  input  wire logic        four_clk_opt,
  // Program memory
  output logic      [9:0]  prog_addr,
  input  wire logic [12:0] prog_data,
  // Machine state
  output logic      [7:0]  acc_out,
  output logic      [7:0]  status_out,
  output logic      [7:0]  ctl_out,
  output logic             irq_enable,
  output logic             timer_counter_clock,
  output logic             cycle_end,
  output logic             asleep,
  output logic             watchdog_clear,
  // Port control registers
  output logic      [3:0]  port_ctrl_sel,
  output logic      [7:0]  port_ctrl_wdata,
  output logic             port_ctrl_we,
  input  wire logic [7:0]  port_ctrl_rdata
);
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_t;

  exec_state_t state_reg, state_next;
  logic [1:0]  phase_reg;
  logic [1:0]  boot_reg;
  logic        opt_s1_reg, opt_s2_reg, opt_reg;
  logic [9:0]  pc_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  ctl_reg;
  logic [7:0]  status_reg;
  logic [7:0]  bank_select_reg;
  logic        irq_reg;
  logic        sleep_reg;
  logic        wdc_reg;
  logic        tcc_reg;
  logic        cyc_reg;
  logic [3:0]  pcs_reg;
  logic [7:0]  pcw_reg;
  logic        pcwe_reg;
  logic [2:0]  sp_reg;
  logic [9:0]  stack_mem [core_decode_pkg::STACK_D];
  logic [7:0]  file_mem  [BANKS*64];

  // Strap crosses in from a pin, so it is synchronised first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      opt_s1_reg <= 1'b0;
      opt_s2_reg <= 1'b0;
      opt_reg    <= 1'b0;
    end else begin
      opt_s1_reg <= four_clk_opt;
      opt_s2_reg <= opt_s1_reg;
      opt_reg    <= opt_s2_reg;
    end
  end

  wire logic [1:0] phase_last = opt_reg ? core_decode_pkg::PHASE_LAST_4
                                        : core_decode_pkg::PHASE_LAST_2;
  // Strap is only trusted once the sync chain has filled after reset
  wire logic       run  = (boot_reg == 2'h3);
  wire logic       step = run && (phase_reg == phase_last) && !sleep_reg;

  wire logic [12:0] insn   = prog_data;
  wire logic [5:0]  raddr  = insn[5:0];
  wire logic [6:0]  rfield = insn[12:6];
  // Accumulator clear sits in the register-form range, so pull it out
  wire logic        is_ctl = (insn[12:6] == 7'h00) ||
                             (insn == core_decode_pkg::OP_ACCZERO);
  wire logic [1:0]  bank = bank_select_reg[core_decode_pkg::BANK_MSB:
                                           core_decode_pkg::BANK_LSB];
  wire logic [7:0]  faddr = {bank, raddr};

  // special registers (pc low, status, bank select) share the file map; port registers do not
  wire logic [7:0] rval =
    (raddr == core_decode_pkg::PCL_ADDR)  ? pc_reg[7:0] :
    (raddr == core_decode_pkg::STAT_ADDR) ? status_reg :
    (raddr == core_decode_pkg::BSEL_ADDR) ? bank_select_reg :
    file_mem[faddr[$clog2(BANKS*64)-1:0]];

  logic [7:0] alu_res;
  logic       alu_c, alu_hc;
  core_alu u_alu (
    .acc        (acc_reg),
    .rval       (rval),
    .rfield     (rfield),
    .result     (alu_res),
    .carry      (alu_c),
    .half_carry (alu_hc)
  );

  wire logic to_reg = !is_ctl && rfield[0] && rfield <= 7'h0F;
  wire logic reg_op = !is_ctl && rfield <= 7'h10 && rfield != 7'h02;
  wire logic [7:0] r_res = (rfield == core_decode_pkg::RF_CLR_R) ? 8'h00
                                                                 : alu_res;
  wire logic zero_only = rfield inside {7'h03, 7'h06, 7'h07, 7'h08,
                                        7'h09, 7'h0A, 7'h0B, 7'h0C,
                                        7'h0D, 7'h10};
  wire logic czh = rfield inside {7'h04, 7'h05, 7'h0E, 7'h0F};

  wire logic       da_lo = acc_reg[3:0] > 4'h9 ||
                           status_reg[core_decode_pkg::FLAG_HC];
  wire logic [8:0] da_s1 = {1'b0, acc_reg} + (da_lo ? 9'h006 : 9'h000);
  wire logic       da_hi = status_reg[core_decode_pkg::FLAG_C] ||
                           da_s1[8] || da_s1[7:4] > 4'h9;
  wire logic [8:0] da_s2 = da_s1 + (da_hi ? 9'h060 : 9'h000);

  // table offset add keeps bits 9,8
  wire logic [8:0] tb_sum = {1'b0, pc_reg[7:0]} + {1'b0, acc_reg};
  wire logic [4:0] tb_hc  = {1'b0, pc_reg[3:0]} + {1'b0, acc_reg[3:0]};

  wire logic is_ret  = insn == core_decode_pkg::OP_RET ||
                       insn == core_decode_pkg::OP_INTERRUPT_EXIT_OP;
  wire logic is_tbl  = insn == core_decode_pkg::OP_TABLE;
  wire logic pc_wr   = reg_op && to_reg &&
                       raddr == core_decode_pkg::PCL_ADDR;
  wire logic [2:0] sp_top = sp_reg - 3'h1;
  wire logic two_cyc = is_ret || is_tbl || pc_wr;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC:  if (step && two_cyc) state_next = ST_FLUSH;
      ST_FLUSH: if (step) state_next = ST_EXEC;
      default:  state_next = ST_EXEC;
    endcase
  end
  wire logic exec = step && state_reg == ST_EXEC;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_EXEC;
      phase_reg <= 2'h0;
      boot_reg  <= 2'h0;
      tcc_reg   <= 1'b0;
      cyc_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      boot_reg  <= run ? boot_reg : boot_reg + 2'h1;
      phase_reg <= (!run || phase_reg == phase_last) ? 2'h0
                                                     : phase_reg + 2'h1;
      // timer clock over two or four
      // Toggles every clock, or every other clock in four-clock mode
      tcc_reg   <= (run && (!opt_reg || phase_reg[0])) ? ~tcc_reg
                                                       : tcc_reg;
      cyc_reg   <= step;
    end
  end

  // Program counter and return stack
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= core_decode_pkg::PC_RST;
      sp_reg <= 3'h0;
    end else if (exec) begin
      if (is_ret) begin
        pc_reg <= stack_mem[sp_top];
        sp_reg <= sp_top;
      end else if (is_tbl) begin
        pc_reg <= {pc_reg[9:8], tb_sum[7:0]};
      end else if (pc_wr) begin
        pc_reg <= {pc_reg[9:8], r_res};
      end else begin
        pc_reg <= pc_reg + 10'h001;
      end
    end
    // Flush cycle leaves pc on the target so that word runs next
  end

  // Only stack entry 0 is loaded, with the reset address while reset is low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) stack_mem[0] <= core_decode_pkg::PC_RST;
  end

  always_ff @(posedge clk_sys) begin
    if (exec && reg_op && to_reg && raddr > core_decode_pkg::BSEL_ADDR)
      file_mem[faddr[$clog2(BANKS*64)-1:0]] <= r_res;
  end

  // Accumulator, control, status and side effects
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg         <= core_decode_pkg::ACC_RST;
      ctl_reg         <= core_decode_pkg::CTL_RST;
      status_reg      <= core_decode_pkg::STAT_RST;
      bank_select_reg <= 8'h00;
      irq_reg         <= 1'b0;
      sleep_reg       <= 1'b0;
      wdc_reg         <= 1'b0;
      pcs_reg         <= 4'h0;
      pcw_reg         <= 8'h00;
      pcwe_reg        <= 1'b0;
    end else begin
      wdc_reg  <= 1'b0;
      pcwe_reg <= 1'b0;
      if (exec && is_ctl) begin
        case (insn)
          core_decode_pkg::OP_IDLE: ;
          core_decode_pkg::OP_DECFIX: begin
            acc_reg <= da_s2[7:0];
            status_reg[core_decode_pkg::FLAG_C] <= da_hi;
          end
          core_decode_pkg::OP_ACC2CTL: ctl_reg <= acc_reg;
          core_decode_pkg::OP_CTL2ACC: acc_reg <= ctl_reg;
          core_decode_pkg::OP_SLEEP: begin
            wdc_reg   <= 1'b1;
            sleep_reg <= 1'b1;
            status_reg[core_decode_pkg::FLAG_T] <= 1'b1;
            status_reg[core_decode_pkg::FLAG_P] <= 1'b0;
          end
          core_decode_pkg::OP_WDCLR: begin
            wdc_reg <= 1'b1;
            status_reg[core_decode_pkg::FLAG_T] <= 1'b1;
            status_reg[core_decode_pkg::FLAG_P] <= 1'b1;
          end
          core_decode_pkg::OP_IRQ_ON:  irq_reg <= 1'b1;
          core_decode_pkg::OP_IRQ_OFF: irq_reg <= 1'b0;
          core_decode_pkg::OP_INTERRUPT_EXIT_OP:    irq_reg <= 1'b1;
          core_decode_pkg::OP_TABLE: begin
            status_reg[core_decode_pkg::FLAG_Z]  <= tb_sum[7:0] == 8'h00;
            status_reg[core_decode_pkg::FLAG_C]  <= tb_sum[8];
            status_reg[core_decode_pkg::FLAG_HC] <= tb_hc[4];
          end
          core_decode_pkg::OP_ACCZERO: begin
            acc_reg <= 8'h00;
            status_reg[core_decode_pkg::FLAG_Z] <= 1'b1;
          end
          default: begin
            if (insn[12:5] == 8'h00 && insn[3:0] > 4'h4) begin
              pcs_reg <= insn[3:0];
              if (!insn[4]) begin
                pcw_reg  <= acc_reg;
                pcwe_reg <= 1'b1;
              end else begin
                acc_reg <= port_ctrl_rdata;
              end
            end
          end
        endcase
      end else if (exec && reg_op) begin
        if (!to_reg)
          acc_reg <= alu_res;
        else if (raddr == core_decode_pkg::STAT_ADDR)
          status_reg <= r_res;
        else if (raddr == core_decode_pkg::BSEL_ADDR)
          bank_select_reg <= r_res;
        if (zero_only || czh)
          status_reg[core_decode_pkg::FLAG_Z] <= r_res == 8'h00;
        if (czh) begin
          status_reg[core_decode_pkg::FLAG_C]  <= alu_c;
          status_reg[core_decode_pkg::FLAG_HC] <= alu_hc;
        end
      end
    end
  end

  assign prog_addr           = pc_reg;
  assign acc_out             = acc_reg;
  assign status_out          = status_reg;
  assign ctl_out             = ctl_reg;
  assign irq_enable          = irq_reg;
  assign timer_counter_clock = tcc_reg;
  assign cycle_end           = cyc_reg;
  assign asleep              = sleep_reg;
  assign watchdog_clear      = wdc_reg;
  assign port_ctrl_sel       = pcs_reg;
  assign port_ctrl_wdata     = pcw_reg;
  assign port_ctrl_we        = pcwe_reg;

  property p_cycle_len;
    @(posedge clk_sys) disable iff (!rst_b)
    (cycle_end && !opt_reg && !asleep) |=> !cycle_end ##1 cycle_end;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("two-clock cycle length wrong");

  property p_ret_flush;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && is_ret) |=> state_reg == ST_FLUSH;
  endproperty
  a_ret_flush: assert property (p_ret_flush)
    else $error("return did not flush");

  property p_idle;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && insn == core_decode_pkg::OP_IDLE) |=>
      $stable(status_reg) && $stable(acc_reg);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle changed state");

  property p_acc_zero_op;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && insn == core_decode_pkg::OP_ACCZERO) |=>
      acc_reg == 8'h00 && status_reg[core_decode_pkg::FLAG_Z];
  endproperty
  a_acc_zero_op: assert property (p_acc_zero_op)
    else $error("accumulator clear wrong");

  property p_wdc;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && insn == core_decode_pkg::OP_WDCLR) |=> watchdog_clear;
  endproperty
  a_wdc: assert property (p_wdc)
    else $error("watchdog clear missing");

  property p_tbl;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && is_tbl) |=> pc_reg[9:8] == $past(pc_reg[9:8]);
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("table add changed high bits");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && insn == core_decode_pkg::OP_IRQ_OFF) |=> !irq_enable;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt disable failed");

  property p_ctl;
    @(posedge clk_sys) disable iff (!rst_b)
    (exec && insn == core_decode_pkg::OP_ACC2CTL) |=>
      ctl_out == $past(acc_reg);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("control write wrong");
endmodule // mcu_instruction_decode_core

/* rtl/core_decode_pkg.sv */
// Shared constants for the instruction decode and execute core
package core_decode_pkg;
  localparam int INSN_W   = 13;
  localparam int DATA_W   = 8;
  localparam int RADDR_W  = 6;
  localparam int PC_W     = 10;
  localparam int STACK_D  = 8;
  // Register map inside a bank
  localparam logic [5:0] PCL_ADDR  = 6'h02;
  localparam logic [5:0] STAT_ADDR = 6'h03;
  localparam logic [5:0] BSEL_ADDR = 6'h04;
  // Bank-select field in the bank-select register
  localparam int BANK_LSB = 6;
  localparam int BANK_MSB = 7;
  // Status bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_HC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_P  = 3;
  localparam int FLAG_T  = 4;
  // Last phase of the instruction cycle, for two or four oscillator clocks per cycle
  localparam logic [1:0] PHASE_LAST_2 = 2'h1;
  localparam logic [1:0] PHASE_LAST_4 = 2'h3;
  // Exact control opcodes
  localparam logic [12:0] OP_IDLE     = 13'h0000;
  localparam logic [12:0] OP_DECFIX   = 13'h0001;
  localparam logic [12:0] OP_ACC2CTL  = 13'h0002;
  localparam logic [12:0] OP_SLEEP    = 13'h0003;
  localparam logic [12:0] OP_WDCLR    = 13'h0004;
  localparam logic [12:0] OP_IRQ_ON   = 13'h0010;
  localparam logic [12:0] OP_IRQ_OFF  = 13'h0011;
  localparam logic [12:0] OP_RET      = 13'h0012;
  localparam logic [12:0] OP_INTERRUPT_EXIT_OP     = 13'h0013;
  localparam logic [12:0] OP_CTL2ACC  = 13'h0014;
  localparam logic [12:0] OP_TABLE    = 13'h0020;
  localparam logic [12:0] OP_ACCZERO  = 13'h0080;
  // Register-form opcode field (bits 12..6)
  localparam logic [6:0] RF_COPY_TO_R = 7'h01;
  localparam logic [6:0] RF_CLR_R     = 7'h03;
  localparam logic [6:0] RF_SUB_A     = 7'h04;
  localparam logic [6:0] RF_SUB_R     = 7'h05;
  localparam logic [6:0] RF_DEC_A     = 7'h06;
  localparam logic [6:0] RF_DEC_R     = 7'h07;
  localparam logic [6:0] RF_OR_A      = 7'h08;
  localparam logic [6:0] RF_OR_R      = 7'h09;
  localparam logic [6:0] RF_AND_A     = 7'h0A;
  localparam logic [6:0] RF_AND_R     = 7'h0B;
  localparam logic [6:0] RF_XOR_A     = 7'h0C;
  localparam logic [6:0] RF_XOR_R     = 7'h0D;
  localparam logic [6:0] RF_ADD_A     = 7'h0E;
  localparam logic [6:0] RF_ADD_R     = 7'h0F;
  localparam logic [6:0] RF_COPY_TO_A = 7'h10;
  // Reset values
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] CTL_RST  = 8'h3F;
  localparam logic [7:0] STAT_RST = 8'h18;
  localparam logic [9:0] PC_RST   = 10'h3FF;
endpackage

/* rtl/core_alu.sv */
// Arithmetic and logic unit with flag results for the decode core
`timescale 1ns/1ps
module core_alu (
  // Operands and selection
  input  wire logic [7:0] acc,
  input  wire logic [7:0] rval,
  input  wire logic [6:0] rfield,
  // Results
  output logic      [7:0] result,
  output logic            carry,
  output logic            half_carry
);
  wire logic [8:0] sub_full = {1'b0, rval} - {1'b0, acc};
  wire logic [4:0] sub_half = {1'b0, rval[3:0]} - {1'b0, acc[3:0]};
  wire logic [8:0] add_full = {1'b0, rval} + {1'b0, acc};
  wire logic [4:0] add_half = {1'b0, rval[3:0]} + {1'b0, acc[3:0]};
  wire logic [7:0] dec_val  = rval - 8'h01;

  always_comb begin
    result     = 8'h00;
    carry      = 1'b0;
    half_carry = 1'b0;
    case (rfield)
      core_decode_pkg::RF_SUB_A, core_decode_pkg::RF_SUB_R: begin
        // Carry means no borrow, as on most 8-bit cores
        result     = sub_full[7:0];
        carry      = ~sub_full[8];
        half_carry = ~sub_half[4];
      end
      core_decode_pkg::RF_DEC_A, core_decode_pkg::RF_DEC_R:
        result = dec_val;
      core_decode_pkg::RF_OR_A, core_decode_pkg::RF_OR_R:
        result = acc | rval;
      core_decode_pkg::RF_AND_A, core_decode_pkg::RF_AND_R:
        result = acc & rval;
      core_decode_pkg::RF_XOR_A, core_decode_pkg::RF_XOR_R:
        result = acc ^ rval;
      core_decode_pkg::RF_ADD_A, core_decode_pkg::RF_ADD_R: begin
        result     = add_full[7:0];
        carry      = add_full[8];
        half_carry = add_half[4];
      end
      core_decode_pkg::RF_COPY_TO_A:
        result = rval;
      core_decode_pkg::RF_COPY_TO_R:
        result = acc;
      default:
        result = 8'h00;
    endcase
  end
endmodule // core_alu

/* verification/prog_rom_model.sv */
// Program memory model feeding instruction words and port read data
`timescale 1ns/1ps
module prog_rom_model (
  // Fetch side
  input  wire logic [9:0]  prog_addr,
  // Answers
  output logic      [12:0] prog_data,
  output logic      [7:0]  port_ctrl_rdata
);
  // Contents loaded by the bench through the hierarchy
  logic [12:0] img    [0:1023];
  logic [7:0]  io_img [0:1023];
  assign prog_data = img[prog_addr];
  // Port data follows the fetch address so it holds for a full cycle
  assign port_ctrl_rdata = io_img[prog_addr];
endmodule // prog_rom_model

/* verification/mcu_instruction_decode_core_tb.sv */
// Self-checking bench for the instruction decode core
`timescale 1ns/1ps
module mcu_instruction_decode_core_tb;
  logic        clk_sys = 1'b0;
  logic        rst_b;
  logic        four_clk_opt;
  logic [9:0]  prog_addr;
  logic [12:0] prog_data;
  logic [7:0]  acc_out, status_out, ctl_out;
  logic [7:0]  port_ctrl_wdata, port_ctrl_rdata;
  logic [3:0]  port_ctrl_sel;
  logic        irq_enable, timer_counter_clock, cycle_end, asleep;
  logic        watchdog_clear, port_ctrl_we;
  logic [7:0]  m_r [0:255];
  logic [7:0]  m_acc, m_ctl;
  logic [1:0]  m_bank;
  logic        m_irq, m_z, m_c, m_hc, tcc_q, tcc_ok;
  logic [31:0] notes [$];
  logic [11:0] wq [$];
  logic [31:0] nt;
  logic [11:0] e;
  logic [9:0]  pc_w, jmp_at, a0;
  int          fails = 0;
  int          cmp_count = 0;
  int          tick = 0;
  int          wd_n, tcc_t, cyc, j;
  int          pop_t [0:1023];
  int          seed = 32'h8BCB;

  always #4 clk_sys = ~clk_sys;

  mcu_instruction_decode_core #(.BANKS(4)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .four_clk_opt(four_clk_opt),
    .prog_addr(prog_addr), .prog_data(prog_data), .acc_out(acc_out),
    .status_out(status_out), .ctl_out(ctl_out), .irq_enable(irq_enable),
    .timer_counter_clock(timer_counter_clock), .cycle_end(cycle_end),
    .asleep(asleep), .watchdog_clear(watchdog_clear),
    .port_ctrl_sel(port_ctrl_sel), .port_ctrl_wdata(port_ctrl_wdata),
    .port_ctrl_we(port_ctrl_we), .port_ctrl_rdata(port_ctrl_rdata)
  );

  prog_rom_model rom (
    .prog_addr(prog_addr),
    .prog_data(prog_data), .port_ctrl_rdata(port_ctrl_rdata)
  );

  task automatic chk(input string nm, input logic [15:0] ex, gt);
    cmp_count++;
    if (gt !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Places one word in memory and, unless it is a sleep, a table add or a write to pc low, notes the state expected after it
  task automatic put(input logic [12:0] w, input logic [7:0] io = 8'h00);
    logic [7:0] a, r, res;
    logic [8:0] s;
    logic [6:0] f;
    logic       rg, nn;
    a = m_acc;
    f = w[12:6];
    r = m_r[{m_bank, w[5:0]}];
    res = a;
    rg = 1'b0;
    nn = 1'b0;
    rom.img[pc_w] = w;
    rom.io_img[pc_w] = io;
    if (w == 13'h0001) begin
      s = {1'b0, a};
      if (a[3:0] > 4'h9 || m_hc) s = s + 9'h006;
      if (s[7:4] > 4'h9 || s[8] || m_c) begin
        s = s + 9'h060;
        m_c = 1'b1;
      end
      res = s[7:0];
    end else if (w == 13'h0002) m_ctl = a;
    else if (w == 13'h0014) res = m_ctl;
    else if (w[12:1] == 12'h008) m_irq = ~w[0];
    else if (w == 13'h0003 || w == 13'h0020) begin
      nn = 1'b1;
      {m_z, m_hc, m_c} = 3'b000;
    end else if (w[12:4] == 9'h000 && w[3:0] > 4'h4) wq.push_back({w[3:0], a});
    else if (w[12:4] == 9'h001) res = io;
    else if (w == 13'h0080) begin
      res = 8'h00;
      m_z = 1'b1;
    end else if (f == 7'h01) rg = 1'b1;
    else if (f >= 7'h03 && f <= 7'h10) begin
      case (f[4:1])
        4'h1: res = 8'h00;
        4'h2: begin
          s = {1'b0, r} - {1'b0, a};
          res = s[7:0];
          m_c = ~s[8];
          m_hc = r[3:0] >= a[3:0];
        end
        4'h3: res = r - 8'h01;
        4'h4: res = a | r;
        4'h5: res = a & r;
        4'h6: res = a ^ r;
        4'h7: begin
          s = {1'b0, a} + {1'b0, r};
          res = s[7:0];
          m_c = s[8];
          m_hc = ({1'b0, a[3:0]} + {1'b0, r[3:0]}) > 5'h0F;
        end
        default: res = r;
      endcase
      m_z = res == 8'h00;
      rg = f == 7'h03 || (f != 7'h10 && f[0]);
    end
    if (!rg) m_acc = res;
    else if (w[5:0] == 6'h04) m_bank = res[7:6];
    else if (w[5:0] == 6'h02) begin
      nn = 1'b1;
      // Fill the gap so a missed jump corrupts the accumulator
      for (int k = pc_w + 1; k < res; k++) rom.img[k] = 13'h0080;
      pc_w = {pc_w[9:8], res} - 10'h001;
    end else m_r[{m_bank, w[5:0]}] = res;
    pc_w = pc_w + 10'h001;
    if (!nn) notes.push_back({pc_w, m_irq, m_ctl, 2'b11, m_z, m_hc, m_c, m_acc});
  endtask

  task automatic build(input logic [7:0] v1, v2);
    for (int k = 0; k < 1024; k++) begin
      rom.img[k] = 13'h0000;
      rom.io_img[k] = 8'h00;
    end
    pc_w = 10'h000;
    m_acc = 8'h00;
    m_ctl = 8'h3F;
    m_bank = 2'h0;
    {m_irq, m_z, m_c, m_hc} = 4'h0;
    put(13'h0015, v1);
    put(13'h0050);
    put(13'h0080);
    put(13'h0390);
    put(13'h0390);
    put(13'h0110);
    put(13'h0019, v2);
    put(13'h0150);
    put(13'h0410);
    put(13'h0190);
    put(13'h01D0);
    for (int k = 0; k < 7; k++) put(13'h0210 + 13'(k * 64));
    put(13'h03D0);
    put(13'h0007);
    put(13'h00D0);
    put(13'h0410);
    put(13'h001A, 8'hC0);
    put(13'h0044);
    put(13'h001B, v2);
    put(13'h0050);
    put(13'h001C, 8'h00);
    put(13'h0044);
    put(13'h0410);
    put(13'h001D, 8'h9A);
    put(13'h0001);
    put(13'h0016, v1);
    put(13'h0002);
    put(13'h0080);
    put(13'h0014);
    put(13'h0010);
    put(13'h0011);
    put(13'h0004);
    while (pc_w[3:0] > 4'hC) put(13'h0000);
    put(13'h001E, 8'h01);
    put(13'h0020);
    put(13'h0000);
    put(13'h001F, 8'h60);
    jmp_at = pc_w;
    put(13'h0042);
    put(13'h0000);
    put(13'h0003);
  endtask

  // Result watcher: takes the oldest note when a step completes
  always @(posedge clk_sys) begin
    tick++;
    tcc_q <= timer_counter_clock;
    if (tick == 30000) begin
      fails++;
      finish_test;
    end else if (rst_b === 1'b1) begin
      if (watchdog_clear === 1'b1) wd_n++;
      if (port_ctrl_we === 1'b1) begin
        e = 12'hFFF;
        if (wq.size() > 0) e = wq.pop_front();
        chk("port_write", {4'h0, e}, {4'h0, port_ctrl_sel, port_ctrl_wdata});
      end
      if (cycle_end === 1'b1 && notes.size() > 0 &&
          prog_addr === notes[0][31:22]) begin
        nt = notes.pop_front();
        pop_t[prog_addr] = tick;
        chk("acc", {8'h00, nt[7:0]}, {8'h00, acc_out});
        chk("status", {11'h000, nt[12:8]}, {11'h000, status_out[4:0]});
        chk("ctl", {8'h00, nt[20:13]}, {8'h00, ctl_out});
        chk("irq", {15'h0000, nt[21]}, {15'h0000, irq_enable});
      end
      if (timer_counter_clock === 1'b1 && tcc_q === 1'b0) begin
        if (tcc_ok) chk("tcc_period", 16'(cyc), 16'(tick - tcc_t));
        tcc_ok = prog_addr > 10'h000 && prog_addr < 10'h020;
        tcc_t = tick;
      end
    end else tcc_ok = 1'b0;
  end

  initial begin
    rst_b = 1'b0;
    four_clk_opt = 1'b0;
    for (int run = 0; run < 4; run++) begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      four_clk_opt <= run[0];
      notes.delete();
      wq.delete();
      wd_n = 0;
      cyc = run[0] ? 4 : 2;
      build(8'($random(seed)), 8'($random(seed)));
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      j = 0;
      while (asleep !== 1'b1 && j < 3000) begin
        @(posedge clk_sys);
        j++;
      end
      repeat (4) @(posedge clk_sys);
      a0 = prog_addr;
      repeat (10) @(posedge clk_sys);
      chk("halt_addr", {6'h00, a0}, {6'h00, prog_addr});
      chk("asleep", 16'h0001, {15'h0000, asleep});
      chk("notes_left", 16'h0000, 16'(notes.size() + wq.size()));
      chk("wd_pulses", 16'h0002, 16'(wd_n));
      chk("cycle_len", 16'(cyc), 16'(pop_t[2] - pop_t[1]));
      chk("jump_len", 16'(3 * cyc), 16'(pop_t[10'h061] - pop_t[jmp_at]));
    end
    finish_test;
  end
endmodule // mcu_instruction_decode_core_tb
